// ==== hw/pfrs_map.svh ====
`ifndef PFRS_MAP_SVH
`define PFRS_MAP_SVH

// ****************************************************************
// vector addresses and restart values
// ****************************************************************
`define PFRS_PF_VECTOR 16'h001C
`define PFRS_PF_VECTOR_OFS 16'h011C
`define PFRS_RESTART_PC 16'h0000

// ****************************************************************
// timing
// ****************************************************************
`define PFRS_GRACE_NS 900000
`define PFRS_CLK_PERIOD_NS 10
`define PFRS_GRACE_CYCLES (`PFRS_GRACE_NS / `PFRS_CLK_PERIOD_NS)

`endif

// ==== hw/pfrs_pkg.sv ====
package pfrs_pkg;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        PFRS_ST_START,
        PFRS_ST_RUN,
        PFRS_ST_GRACE,
        PFRS_ST_DOWN,
        PFRS_ST_WAIT_UP
    } pfrs_state_type;

    // ****************************************************************
    // processor-facing control bundle
    // ****************************************************************
    typedef struct packed {
        logic irq_req;
        logic [15:0] irq_vector;
        logic halt;
        logic mem_protect;
        logic pc_load;
        logic [15:0] pc_value;
        logic run;
    } pfrs_cpu_ctl_type;

    // ****************************************************************
    // instruction strobes decoded by the processor
    // ****************************************************************
    typedef struct packed {
        logic global_irq_unmask_instr;
        logic global_irq_mask_instr;
        logic power_loss_irq_unmask_instr;
        logic power_loss_irq_mask_instr;
        logic irq_ack;
    } pfrs_cpu_req_type;

endpackage : pfrs_pkg

// ==== hw/pfrs_pin_sync.sv ====
`timescale 1ns/1ps

// three-stage pin synchroniser; a change counts once stages 2 and 3 agree
module pfrs_pin_sync (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    // pin and result
    input wire logic pin_i,
    output logic level_o
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ****************************************************************
    // shift chain
    // ****************************************************************
    // s1 is read only by s2
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (clk_en_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ****************************************************************
    // agreement filter
    // ****************************************************************
    // reset low: power treated as bad until proven good
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_o <= 1'b0;
        end else if (clk_en_i && (s2_q == s3_q)) begin
            level_o <= s3_q;
        end
    end

endmodule : pfrs_pin_sync

// ==== hw/pfrs_sequencer.sv ====
`timescale 1ns/1ps
`include "pfrs_map.svh"

module pfrs_sequencer
    import pfrs_pkg::*;
#(
    parameter int GRACE_CYCLES = `PFRS_GRACE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    // power monitor and straps (pins, asynchronous)
    input wire logic power_good_i,
    input wire logic vector_relocate_strap_n_i,
    input wire logic irq_outside_global_i,
    // processor side
    input wire pfrs_cpu_req_type cpu_req_i,
    output pfrs_cpu_ctl_type cpu_ctl_o,
    output pfrs_state_type state_o
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic pwr_ok;
    logic ofs_n;
    logic outside;

    pfrs_pin_sync u_sync_pwr (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .clk_en_i(clk_en_i),
        .pin_i(power_good_i),
        .level_o(pwr_ok)
    );

    pfrs_pin_sync u_sync_ofs (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .clk_en_i(clk_en_i),
        .pin_i(vector_relocate_strap_n_i),
        .level_o(ofs_n)
    );

    pfrs_pin_sync u_sync_opt (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .clk_en_i(clk_en_i),
        .pin_i(irq_outside_global_i),
        .level_o(outside)
    );

    // ****************************************************************
    // state and timers
    // ****************************************************************
    pfrs_state_type state_q;
    logic [31:0] grace_cnt_q;
    logic global_en_q;
    logic pf_en_q;
    logic irq_en;
    // processor controls, one register for each
    logic irq_req_q;
    logic [15:0] irq_vector_q;
    logic halt_q;
    logic mem_protect_q;
    logic pc_load_q;
    logic [15:0] pc_value_q;
    logic run_q;

    // wired option picks which enable gates the request
    always_comb begin
        irq_en = outside ? pf_en_q : global_en_q;
    end

    // ****************************************************************
    // interrupt enables
    // ****************************************************************
    // dedicated instructions are ignored without the wiring option;
    // an acknowledge masks globally, as a jump-and-store does
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            global_en_q <= 1'b0;
            pf_en_q <= 1'b0;
        end else if (clk_en_i) begin
            if (cpu_req_i.global_irq_unmask_instr) begin
                global_en_q <= 1'b1;
            end else if (cpu_req_i.global_irq_mask_instr || cpu_req_i.irq_ack) begin
                global_en_q <= 1'b0;
            end
            if (outside && cpu_req_i.power_loss_irq_unmask_instr) begin
                pf_en_q <= 1'b1;
            end else if (outside && cpu_req_i.power_loss_irq_mask_instr) begin
                pf_en_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // reset is power application: always start at word zero
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= PFRS_ST_WAIT_UP;
            grace_cnt_q <= 32'h0000_0000;
        end else if (clk_en_i) begin
            unique case (state_q)
                PFRS_ST_WAIT_UP: begin
                    if (pwr_ok) begin
                        state_q <= PFRS_ST_START;
                    end
                end
                PFRS_ST_START: begin
                    state_q <= PFRS_ST_RUN;
                end
                PFRS_ST_RUN: begin
                    if (!pwr_ok) begin
                        state_q <= PFRS_ST_GRACE;
                        grace_cnt_q <= 32'h0000_0000;
                    end
                end
                PFRS_ST_GRACE: begin
                    // grace runs once the routine has been entered (ack);
                    // a stray ack with no request raised does not start it
                    if ((cpu_req_i.irq_ack && irq_req_q) || grace_cnt_q != 32'h0000_0000) begin
                        if (grace_cnt_q >= 32'(GRACE_CYCLES - 1)) begin
                            state_q <= PFRS_ST_DOWN;
                        end else begin
                            grace_cnt_q <= grace_cnt_q + 32'h0000_0001;
                        end
                    end
                end
                PFRS_ST_DOWN: begin
                    // requests ignored; only restored power releases
                    if (pwr_ok) begin
                        state_q <= PFRS_ST_START;
                    end
                end
                default: begin
                    state_q <= PFRS_ST_WAIT_UP;
                end
            endcase
        end
    end

    // ****************************************************************
    // processor controls, all registered
    // ****************************************************************
    // registered copy of the state, for observation only
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_o <= PFRS_ST_WAIT_UP;
        end else if (clk_en_i) begin
            state_o <= state_q;
        end
    end

    // vector follows the strap; the restart word is never relocated
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_vector_q <= `PFRS_PF_VECTOR;
            pc_value_q <= `PFRS_RESTART_PC;
        end else if (clk_en_i) begin
            irq_vector_q <= ofs_n ? `PFRS_PF_VECTOR : `PFRS_PF_VECTOR_OFS;
            pc_value_q <= `PFRS_RESTART_PC;
        end
    end

    // program counter load lasts exactly the one start cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_load_q <= 1'b0;
        end else if (clk_en_i) begin
            pc_load_q <= (state_q == PFRS_ST_START);
        end
    end

    // halt, protect and run move only at start or at shutdown, so no
    // processor request can loosen them in between
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            halt_q <= 1'b1;
            mem_protect_q <= 1'b1;
            run_q <= 1'b0;
        end else if (clk_en_i) begin
            if (state_q == PFRS_ST_START) begin
                mem_protect_q <= 1'b0;
                halt_q <= 1'b0;
                run_q <= 1'b1;
            end else if (state_q == PFRS_ST_DOWN || state_q == PFRS_ST_WAIT_UP) begin
                mem_protect_q <= 1'b1;
                halt_q <= 1'b1;
                run_q <= 1'b0;
            end
        end
    end

    // limitation: a masked request stays pending until acked or power
    // is cut, so a late unmask still delivers it;
    // request set wins over ack in the same cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_req_q <= 1'b0;
        end else if (clk_en_i) begin
            if (state_q == PFRS_ST_GRACE && irq_en && !irq_req_q
                && grace_cnt_q == 32'h0000_0000) begin
                irq_req_q <= 1'b1;
            end else if (cpu_req_i.irq_ack || state_q != PFRS_ST_GRACE) begin
                irq_req_q <= 1'b0;
            end
        end
    end

    // bundle is pure wiring of the registers above
    assign cpu_ctl_o = {irq_req_q, irq_vector_q, halt_q, mem_protect_q, pc_load_q, pc_value_q, run_q};

endmodule : pfrs_sequencer

// ==== tb/pfrs_seq_sva.sv ====
`timescale 1ns/1ps
// ****************************************************************
// sequencer port checks
// ****************************************************************
module pfrs_seq_chk
    import pfrs_pkg::*;
#(
    parameter int GRACE_CYCLES = 90000
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    // pins and processor side
    input wire logic power_good_i,
    input wire logic vector_relocate_strap_n_i,
    input wire logic irq_outside_global_i,
    input wire pfrs_cpu_req_type cpu_req_i,
    input wire pfrs_cpu_ctl_type cpu_ctl_o,
    input wire pfrs_state_type state_o
);
    int ack_cnt_q;
    // edges since the routine began; saturates so it never wraps
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_cnt_q <= 0;
        end else if (cpu_req_i.irq_ack && cpu_ctl_o.irq_req) begin
            ack_cnt_q <= 0;
        end else if (ack_cnt_q < 1000) begin
            ack_cnt_q <= ack_cnt_q + 1;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    pf_vector_a: assert property (
        cpu_ctl_o.irq_req |-> cpu_ctl_o.irq_vector ==
        (vector_relocate_strap_n_i ? 16'h001C : 16'h011C)) else $error("bad vector");
    restart_values_a: assert property (
        cpu_ctl_o.pc_load |-> cpu_ctl_o.pc_value == 16'h0000 && cpu_ctl_o.run
        && !cpu_ctl_o.halt && !cpu_ctl_o.mem_protect) else $error("bad restart");
    load_pulse_a: assert property (
        cpu_ctl_o.pc_load |=> !cpu_ctl_o.pc_load) else $error("long pc load");
    power_ok_a: assert property (
        cpu_ctl_o.pc_load |-> $past(power_good_i, 3)) else $error("early start");
    grace_time_a: assert property (
        $rose(cpu_ctl_o.halt) |-> ack_cnt_q inside {[GRACE_CYCLES - 1:GRACE_CYCLES + 1]})
        else $error("halt off grace");
    hold_down_a: assert property (
        $fell(cpu_ctl_o.halt) |-> cpu_ctl_o.pc_load) else $error("halt released");
    halt_protect_a: assert property (
        cpu_ctl_o.halt |-> cpu_ctl_o.mem_protect && !cpu_ctl_o.run) else $error("unsafe halt");
    loss_irq_a: assert property (
        $rose(cpu_ctl_o.irq_req) |-> !$past(power_good_i, 3)) else $error("spurious irq");
endmodule : pfrs_seq_chk

bind pfrs_sequencer pfrs_seq_chk #(.GRACE_CYCLES(GRACE_CYCLES)) pfrs_seq_chk_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i),
    .power_good_i(power_good_i), .vector_relocate_strap_n_i(vector_relocate_strap_n_i),
    .irq_outside_global_i(irq_outside_global_i), .cpu_req_i(cpu_req_i),
    .cpu_ctl_o(cpu_ctl_o), .state_o(state_o));

// ==== tb/pfrs_cpu_model.sv ====
`timescale 1ns/1ps
// processor core stand-in: instruction strobes and interrupt ack
module pfrs_cpu_model
    import pfrs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // bench controls
    input wire logic [3:0] instr_i,
    input wire logic [3:0] ack_delay_i,
    // sequencer side
    input wire pfrs_cpu_ctl_type cpu_ctl_i,
    output pfrs_cpu_req_type cpu_req_o,
    output logic was_running_o
);
    logic [3:0] wait_q;
    logic was_running_q;
    logic ack_due;
    // one ack per request, after a chosen delay
    always_comb begin
        ack_due = cpu_ctl_i.irq_req && !cpu_req_o.irq_ack && (wait_q >= ack_delay_i);
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_q <= '0;
            cpu_req_o <= '0;
        end else begin
            cpu_req_o <= {instr_i, ack_due};
            if (cpu_ctl_i.irq_req && !cpu_req_o.irq_ack) begin
                wait_q <= ack_due ? 4'h0 : wait_q + 4'h1;
            end
        end
    end
    assign was_running_o = was_running_q;
    // flag lives in core memory, so reset leaves it alone
    always_ff @(posedge ref_clk_i) begin
        if (cpu_req_o.irq_ack) begin
            was_running_q <= 1'b1;
        end
    end
endmodule : pfrs_cpu_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import pfrs_pkg::*;
    localparam int GRACE = 20;
    localparam logic [7:0] SEQ [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic pg = 1'b0;
    logic strap_n = 1'b1;
    logic opt = 1'b0;
    logic [3:0] instr = '0;
    logic [3:0] dly = '0;
    logic en = 1'b1;
    logic was_run;
    pfrs_state_type st;
    pfrs_cpu_req_type req;
    pfrs_cpu_ctl_type ctl;
    int n_fail = 0;
    int total_checks = 0;
    int n;
    pfrs_sequencer #(.GRACE_CYCLES(GRACE)) pfrs_sequencer_inst (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(en), .power_good_i(pg),
        .vector_relocate_strap_n_i(strap_n), .irq_outside_global_i(opt),
        .cpu_req_i(req), .cpu_ctl_o(ctl), .state_o(st));
    pfrs_cpu_model pfrs_cpu_model_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .instr_i(instr), .ack_delay_i(dly), .cpu_ctl_i(ctl), .cpu_req_o(req),
        .was_running_o(was_run));
    // 100 mhz clock
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
        total_checks++;
        if (seen_v !== exp_v) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen_v, exp_v);
        end
    endtask : check
    task automatic stop_test();
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    function automatic logic [15:0] exp_vec(input logic relocate_n);
        return relocate_n ? 16'h001C : 16'h011C;
    endfunction : exp_vec
    // inputs move 1 ns after the edge, clear of sampling
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask : tick
    // bounded wait on pc_load (0), irq_req (1) or halt (2)
    task automatic wait_for(input int which, input int lim, output logic hit);
        hit = 1'b0;
        for (n = 0; n < lim && !hit; n++) begin
            tick(1);
            hit = (which == 0) ? ctl.pc_load : (which == 1) ? ctl.irq_req : ctl.halt;
        end
    endtask : wait_for
    task automatic pulse(input logic [3:0] code);
        instr = code;
        tick(1);
        instr = '0;
        tick(2);
    endtask : pulse
    task automatic power_up();
        logic hit;
        pg = 1'b1;
        wait_for(0, 40, hit);
        check(hit, 1'b1);
        check({ctl.run, ctl.halt, ctl.mem_protect}, 3'b100);
        check(ctl.pc_value, 16'h0000);
        check(st, PFRS_ST_START);
    endtask : power_up
    // stuck run guard
    initial begin
        #100_000;
        n_fail++;
        stop_test();
    end
    initial begin
        logic hit;
        logic [1:0] k;
        void'($urandom(32'h07bf));
        tick(6);
        nrst_i = 1'b1;
        tick(20);
        check({ctl.run, ctl.halt}, 2'b01);
        // every wiring, strap and mask combination, effective instruction first
        for (int cfg = 0; cfg < 8; cfg++) begin
            nrst_i = 1'b0;
            opt = cfg[0];
            strap_n = cfg[1];
            k = {opt, cfg[2]};
            pg = 1'b0;
            dly = 4'($urandom_range(0, 6));
            tick(6);
            nrst_i = 1'b1;
            tick(2);
            power_up();
            pulse(SEQ[k][7:4]);
            pulse(SEQ[k][3:0]);
            tick($urandom_range(1, 8));
            // power drops while frozen: nothing may move until enabled
            en = 1'b0;
            pg = 1'b0;
            tick(12);
            check({ctl.irq_req, ctl.run}, 2'b01);
            check(st, PFRS_ST_RUN);
            en = 1'b1;
            wait_for(1, 30, hit);
            check(hit, !k[0]);
            if (hit) begin
                check(ctl.irq_vector, exp_vec(strap_n));
                wait_for(2, GRACE + 30, hit);
                check({hit, n >= GRACE}, 2'b11);
                check({ctl.run, ctl.mem_protect}, 2'b01);
                check(st, PFRS_ST_DOWN);
                pulse(4'hA);
                check({ctl.halt, ctl.mem_protect, ctl.pc_load}, 3'b110);
                power_up();
                check(was_run, 1'b1);
            end
        end
        stop_test();
    end
endmodule : testbench
